// ==== sysdec_far_model.sv ====
// Far-side model of the decoder: one region target and one external memory.
`timescale 1ns/1ps
`default_nettype none
`include "sysdec_map.svh"

module sysdec_far (
  // Clock, reset and answer delay.
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [3:0]               dly,
  // Region target.
  input  wire logic                     tgt_valid,
  input  wire logic [31:0]              tgt_addr,
  output logic                          tgt_ready,
  output logic      [31:0]              tgt_rdata,
  // External memory pins.
  input  wire logic                     ext_cs,
  input  wire logic                     ext_we,
  input  wire logic                     ext_oe,
  input  wire logic [`SD_EXT_ABITS-1:0] ext_addr,
  input  wire logic [15:0]              ext_dout,
  output logic      [15:0]              ext_din
);
  logic [3:0] cnt;
  logic [7:0] mem [256];
  logic [7:0] a;

  assign a = ext_addr[7:0];

  // ----------------------------------------------------------------------
  // Target answers dly+1 cycles after it sees tgt_valid; its data is inverted between answers.
  // ----------------------------------------------------------------------
  // The inversion keeps a late sample by the decoder from matching by luck.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 4'h0;
      tgt_ready <= 1'b0;
      tgt_rdata <= 32'h0;
    end else if (tgt_valid && !tgt_ready && cnt == dly) begin
      cnt       <= 4'h0;
      tgt_ready <= 1'b1;
      tgt_rdata <= tgt_addr ^ 32'h5A5A5A5A;
    end else begin
      cnt       <= (tgt_valid && !tgt_ready) ? cnt + 4'h1 : 4'h0;
      tgt_ready <= 1'b0;
      tgt_rdata <= ~tgt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // External memory, byte wide store; reads show two bytes, low byte first.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ext_cs && ext_we) mem[a] <= ext_dout[7:0];
    ext_din <= (ext_cs && ext_oe) ? {mem[a + 8'h01], mem[a]} : ~ext_din;
  end
endmodule : sysdec_far
`default_nettype wire

// ==== sysdec_map.svh ====
// Address map constants and timing counts for the system address decoder.
`ifndef SYSDEC_MAP_SVH
`define SYSDEC_MAP_SVH

// ----------------------------------------------------------------------
// Region boundaries
// ----------------------------------------------------------------------
`define SD_CODE_LAST    32'h1FFFFFFF
`define SD_SRAM_BASE    32'h20000000
`define SD_SRAM_LAST    32'h3FFFFFFF
`define SD_BB_SIZE      32'h00100000
`define SD_ALIAS_BASE   32'h22000000
`define SD_ALIAS_SIZE   32'h02000000
`define SD_PERIPH_LAST  32'h5FFFFFFF
`define SD_EXTRAM_BASE  32'h60000000
`define SD_EXTRAM_LAST  32'h9FFFFFFF
`define SD_EXTPER_LAST  32'hDFFFFFFF
`define SD_INTPER_BASE  32'hE0000000
`define SD_PPB_LAST     32'hE00FFFFF

// ----------------------------------------------------------------------
// Peripheral sub-windows
// ----------------------------------------------------------------------
`define SD_CLK_FIRST    32'h40004000
`define SD_CLK_LAST     32'h400042FF
`define SD_EMPC_FIRST   32'h40005400
`define SD_EMPC_LAST    32'h400054FF

// ----------------------------------------------------------------------
// Memories and external port timing
// ----------------------------------------------------------------------
`define SD_SRAM_WORDS   8192
`define SD_EXT_ABITS    24
`define SD_EXT_BUS_MHZ  33
`define SD_EXT_BUS_CYC  4
`define SD_REF_MHZ      100
`define SD_EXT_CYC      ((`SD_EXT_BUS_CYC * `SD_REF_MHZ + `SD_EXT_BUS_MHZ - 1) / `SD_EXT_BUS_MHZ)

`endif

// ==== sysdec_pkg.sv ====
// Types shared by the system address decoder files.
package sysdec_pkg;

  // Address region of an access.
  typedef enum logic [2:0] {
    RG_CODE, RG_SRAM, RG_ALIAS, RG_PERIPH, RG_EXTRAM, RG_EXTPER, RG_INTPER
  } sysdec_region_t;

  // Processor bus that carries an access.
  typedef enum logic [1:0] {
    BUS_INSTRUCTION_CODE_BUS, BUS_DATA_CODE_BUS, BUS_SYSTEM, BUS_PPB
  } sysdec_bus_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    S_IDLE, S_MRD, S_MCAP, S_MWR, S_EXT, S_TGT, S_RSP
  } sysdec_state_t;

endpackage : sysdec_pkg

// ==== sysdec_ram.sv ====
// Byte-writable SRAM with registered read data.
`timescale 1ns/1ps
`default_nettype none

module sysdec_ram #(
  parameter int WORDS = 8192,
  parameter int AW    = 13
) (
  // Clock.
  input  wire logic          clk,
  // Access.
  input  wire logic          we,
  input  wire logic [3:0]    be,
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   wdata,
  // Read data, one cycle after the address.
  output logic      [31:0]   rdata
);

  logic [31:0] mem [WORDS];

  // Read returns the old word when a write hits the same address.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (we && be[i]) begin
        mem[addr][8*i +: 8] <= wdata[8*i +: 8];
      end
    end
    rdata <= mem[addr];
  end

endmodule : sysdec_ram

`default_nettype wire

// ==== sysdec_tb_top.sv ====
// Self-checking testbench of the system address decoder.
`timescale 1ns/1ps
`default_nettype none
`include "sysdec_map.svh"

module sysdec_tb_top;
  import sysdec_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rsp_rdata, tgt_addr, tgt_wdata, tgt_rdata;
  logic [1:0] req_size = 2'h0, tgt_size;
  logic req_ready, rsp_valid, rsp_err, clk_blk_sel, emp_ctrl_sel, tgt_valid, tgt_write;
  logic tgt_ready, ext_cs, ext_we, ext_oe, ext_sync, ext_doe;
  logic cfg_ext_w16 = 1'b0, cfg_ext_sync = 1'b1;
  logic [`SD_EXT_ABITS-1:0] ext_addr, cap_a;
  logic [15:0] ext_dout, ext_din, cap_d;
  logic [2:0] cap_c;
  logic [3:0] dly = 4'h0;
  sysdec_bus_t bus_sel;
  sysdec_region_t region;
  int n_mismatch = 0, tests_run = 0, n;

  // Clock of 10 ns; external cycles shortened to 2 for a brisk run.
  always #5 ref_clk = ~ref_clk;

  sysdec_top #(.SRAM_WORDS(64), .EXT_CYC(2)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write), .req_size(req_size),
    .req_fetch(req_fetch), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .bus_sel(bus_sel),
    .region(region), .clk_blk_sel(clk_blk_sel), .emp_ctrl_sel(emp_ctrl_sel),
    .tgt_valid(tgt_valid), .tgt_addr(tgt_addr), .tgt_write(tgt_write), .tgt_size(tgt_size),
    .tgt_wdata(tgt_wdata), .tgt_ready(tgt_ready), .tgt_rdata(tgt_rdata),
    .cfg_ext_w16(cfg_ext_w16), .cfg_ext_sync(cfg_ext_sync), .ext_cs(ext_cs),
    .ext_we(ext_we), .ext_oe(ext_oe), .ext_sync(ext_sync), .ext_addr(ext_addr),
    .ext_dout(ext_dout), .ext_doe(ext_doe), .ext_din(ext_din));

  sysdec_far far (.clk(ref_clk), .rst_n(rst_n), .dly(dly), .tgt_valid(tgt_valid),
    .tgt_addr(tgt_addr), .tgt_ready(tgt_ready), .tgt_rdata(tgt_rdata), .ext_cs(ext_cs),
    .ext_we(ext_we), .ext_oe(ext_oe), .ext_addr(ext_addr), .ext_dout(ext_dout),
    .ext_din(ext_din));

  // Last external unit seen on the pins.
  always @(posedge ref_clk) if (ext_cs === 1'b1)
    {cap_a, cap_d, cap_c} <= {ext_addr, ext_dout, ext_we, ext_oe, ext_doe};

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One access; n returns the cycle, counted from the take, that shows rsp_valid.
  task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] s,
                     input logic f, input logic [31:0] d);
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin @(posedge ref_clk); #1; n++; end
    if (n >= 50) begin n_mismatch++; summarize(); end
    {req_addr, req_write, req_size, req_fetch, req_wdata, req_valid} = {a, w, s, f, d, 1'b1};
    @(posedge ref_clk); #1;
    req_valid = 1'b0;
    n = 1;
    while (rsp_valid !== 1'b1 && n < 200) begin @(posedge ref_clk); #1; n++; end
    if (n >= 200) begin n_mismatch++; summarize(); end
  endtask : acc

  // Routed access to a target; route outputs and returned data are judged.
  task automatic rt(input logic [31:0] a, input logic f, input sysdec_bus_t b,
                    input sysdec_region_t r, input logic cs, input logic es);
    dly = a[2] ? 4'h5 : 4'h0;
    acc(a, 1'b0, 2'h2, f, 32'h0);
    chk("bus", b, bus_sel);
    chk("region", r, region);
    chk("clk_sel", cs, clk_blk_sel);
    chk("emp_sel", es, emp_ctrl_sel);
    chk("tgt_addr", a, tgt_addr);
    chk("rdata", a ^ 32'h5A5A5A5A, rsp_rdata);
  endtask : rt

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_sram();
    acc(32'h20000020, 1'b1, 2'h2, 1'b0, 32'hCAFE1234);
    chk("wr_cyc", 2, n);
    acc(32'h20000021, 1'b0, 2'h0, 1'b0, 32'h0);
    chk("rd_cyc", 3, n);
    chk("byte", 32'h12, rsp_rdata);
    chk("bus", BUS_SYSTEM, bus_sel);
  endtask : t_sram

  task automatic t_alias();
    acc(32'h20000004, 1'b1, 2'h2, 1'b0, 32'hFFFF0000);
    acc(32'h22000094, 1'b1, 2'h2, 1'b0, 32'hFFFFFFF1);
    chk("awr_cyc", 3, n);
    acc(32'h220000C0, 1'b1, 2'h2, 1'b0, 32'hFFFFFFFE);
    acc(32'h20000004, 1'b0, 2'h2, 1'b0, 32'h0);
    chk("word", 32'hFFFE0020, rsp_rdata);
    acc(32'h22000094, 1'b0, 2'h2, 1'b0, 32'h0);
    chk("bit1", 32'h1, rsp_rdata);
    chk("region", RG_ALIAS, region);
    acc(32'h220000BC, 1'b0, 2'h2, 1'b0, 32'h0);
    chk("bit0", 32'h0, rsp_rdata);
  endtask : t_alias

  task automatic t_unal();
    acc(32'h20000010, 1'b1, 2'h2, 1'b0, 32'h0);
    acc(32'h20000014, 1'b1, 2'h2, 1'b0, 32'h0);
    acc(32'h20000011, 1'b1, 2'h2, 1'b0, 32'h44332211);
    chk("uwr_cyc", 3, n);
    acc(32'h20000011, 1'b0, 2'h2, 1'b0, 32'h0);
    chk("urd_cyc", 5, n);
    chk("uword", 32'h44332211, rsp_rdata);
    acc(32'h20000013, 1'b0, 2'h1, 1'b0, 32'h0);
    chk("uhalf", 32'h4433, rsp_rdata);
    acc(32'h20000014, 1'b0, 2'h2, 1'b0, 32'h0);
    chk("next", 32'h44, rsp_rdata);
  endtask : t_unal

  task automatic t_route();
    rt(32'h00000000, 1'b1, BUS_INSTRUCTION_CODE_BUS, RG_CODE, 1'b0, 1'b0);
    rt(32'h1FFFFFFC, 1'b0, BUS_DATA_CODE_BUS, RG_CODE, 1'b0, 1'b0);
    rt(32'h30000004, 1'b1, BUS_SYSTEM, RG_SRAM, 1'b0, 1'b0);
    rt(32'h40004000, 1'b0, BUS_SYSTEM, RG_PERIPH, 1'b1, 1'b0);
    rt(32'h400042FC, 1'b0, BUS_SYSTEM, RG_PERIPH, 1'b1, 1'b0);
    rt(32'h40004300, 1'b0, BUS_SYSTEM, RG_PERIPH, 1'b0, 1'b0);
    rt(32'h40005400, 1'b0, BUS_SYSTEM, RG_PERIPH, 1'b0, 1'b1);
    rt(32'h400054FC, 1'b0, BUS_SYSTEM, RG_PERIPH, 1'b0, 1'b1);
    rt(32'h40005500, 1'b0, BUS_SYSTEM, RG_PERIPH, 1'b0, 1'b0);
    rt(32'hDFFFFFFC, 1'b0, BUS_SYSTEM, RG_EXTPER, 1'b0, 1'b0);
    rt(32'hE0000000, 1'b0, BUS_PPB, RG_INTPER, 1'b0, 1'b0);
    rt(32'hE00FFFFC, 1'b0, BUS_PPB, RG_INTPER, 1'b0, 1'b0);
    rt(32'hE0100000, 1'b0, BUS_SYSTEM, RG_INTPER, 1'b0, 1'b0);
    acc(32'h40000000, 1'b1, 2'h1, 1'b0, 32'h00001234);
    chk("tgt_write", 1, tgt_write);
    chk("tgt_size", 1, tgt_size);
    chk("tgt_wdata", 32'h1234, tgt_wdata);
    chk("wr_rdata", 0, rsp_rdata);
  endtask : t_route

  task automatic t_ext();
    acc(32'h60ABCDEF, 1'b1, 2'h0, 1'b0, 32'h5C);
    chk("ext_cyc", 3, n);
    chk("ext_wctl", 3'b101, cap_c);
    chk("ext_addr", 24'hABCDEF, cap_a);
    chk("ext_dout", 32'h5C, cap_d[7:0]);
    chk("ext_sync", 1, ext_sync);
    acc(32'h60000010, 1'b1, 2'h1, 1'b0, 32'hBEEF);
    chk("w8_cyc", 5, n);
    acc(32'h60000010, 1'b0, 2'h1, 1'b0, 32'h0);
    chk("w8_rd", 32'hBEEF, rsp_rdata);
    chk("ext_rctl", 3'b010, cap_c);
    chk("ext_raddr", 24'h000011, cap_a);
    acc(32'h61000000, 1'b0, 2'h2, 1'b0, 32'h0);
    chk("span_err", 1, rsp_err);
    acc(32'h60000010, 1'b0, 2'h1, 1'b1, 32'h0);
    chk("f8_err", 1, rsp_err);
    {cfg_ext_w16, cfg_ext_sync} = 2'b10;
    acc(32'h60000010, 1'b0, 2'h1, 1'b1, 32'h0);
    chk("f16_err", 0, rsp_err);
    chk("w16_cyc", 3, n);
    chk("f16_rd", 32'hBEEF, rsp_rdata);
    chk("ext_async", 0, ext_sync);
  endtask : t_ext

  // ----------------------------------------------------------------------
  // Main sequence: reset, then every scenario.
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    chk("ready_rst", 0, req_ready);
    rst_n = 1'b1;
    n = 0;
    do begin @(posedge ref_clk); #1; n++; end while (req_ready !== 1'b1 && n < 10);
    chk("ready_edge", 3, n);
    t_sram();
    t_alias();
    t_unal();
    t_route();
    t_ext();
    summarize();
  end
endmodule : sysdec_tb_top
`default_nettype wire

// ==== sysdec_top.sv ====
// System address decoder: region decode, bus choice, bit-band and external port.
`timescale 1ns/1ps
`default_nettype none
`include "sysdec_map.svh"

module sysdec_top #(
  parameter int SRAM_WORDS = `SD_SRAM_WORDS,
  parameter int EXT_CYC    = `SD_EXT_CYC
) (
  // Clock and reset.
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // Request from the core.
  input  wire logic                        req_valid,
  input  wire logic [31:0]                 req_addr,
  input  wire logic                        req_write,
  input  wire logic [1:0]                  req_size,
  input  wire logic                        req_fetch,
  input  wire logic [31:0]                 req_wdata,
  output logic                             req_ready,
  // Response to the core.
  output logic                             rsp_valid,
  output logic      [31:0]                 rsp_rdata,
  output logic                             rsp_err,
  // Routing of the current access.
  output sysdec_pkg::sysdec_bus_t          bus_sel,
  output sysdec_pkg::sysdec_region_t       region,
  output logic                             clk_blk_sel,
  output logic                             emp_ctrl_sel,
  // Generic region target.
  output logic                             tgt_valid,
  output logic      [31:0]                 tgt_addr,
  output logic                             tgt_write,
  output logic      [1:0]                  tgt_size,
  output logic      [31:0]                 tgt_wdata,
  input  wire logic                        tgt_ready,
  input  wire logic [31:0]                 tgt_rdata,
  // External port configuration.
  input  wire logic                        cfg_ext_w16,
  input  wire logic                        cfg_ext_sync,
  // External memory port pins.
  output logic                             ext_cs,
  output logic                             ext_we,
  output logic                             ext_oe,
  output logic                             ext_sync,
  output logic      [`SD_EXT_ABITS-1:0]    ext_addr,
  output logic      [15:0]                 ext_dout,
  output logic                             ext_doe,
  input  wire logic [15:0]                 ext_din
);
  import sysdec_pkg::*;

  localparam int AW       = $clog2(SRAM_WORDS);
  localparam int EXT_LAST = EXT_CYC - 1; // Cycles after the first one of an external unit.

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_q1_r;
  logic srst_n;

  // Assert at once, release after two edges so no flop leaves reset early.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1_r <= 1'b0;
      srst_n   <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      srst_n   <= rst_q1_r;
    end
  end

  // ----------------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------------
  function automatic sysdec_region_t region_of(input logic [31:0] a);
    if (a <= `SD_CODE_LAST)                                  return RG_CODE;
    else if (a <= `SD_SRAM_LAST)
      return ((a - `SD_ALIAS_BASE) < `SD_ALIAS_SIZE) ? RG_ALIAS : RG_SRAM;
    else if (a <= `SD_PERIPH_LAST)                           return RG_PERIPH;
    else if (a <= `SD_EXTRAM_LAST)                           return RG_EXTRAM;
    else if (a <= `SD_EXTPER_LAST)                           return RG_EXTPER;
    else                                                     return RG_INTPER;
  endfunction : region_of

  function automatic sysdec_bus_t bus_of(input logic [31:0] a, input logic f);
    if (a <= `SD_CODE_LAST)                          return f ? BUS_INSTRUCTION_CODE_BUS : BUS_DATA_CODE_BUS;
    else if (a >= `SD_INTPER_BASE && a <= `SD_PPB_LAST) return BUS_PPB;
    else                                             return BUS_SYSTEM;
  endfunction : bus_of

  function automatic logic [31:0] size_mask(input logic [1:0] s);
    case (s)
      2'h0:    return 32'h000000FF;
      2'h1:    return 32'h0000FFFF;
      default: return 32'hFFFFFFFF;
    endcase
  endfunction : size_mask

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  sysdec_state_t  st_r, st_nxt;
  sysdec_region_t reg_r, reg_nxt;
  sysdec_bus_t    bus_r, bus_nxt;
  logic [31:0] addr_r, addr_nxt, wd_r, wd_nxt, rd_r, rd_nxt;
  logic [63:0] buf_r, buf_nxt;
  logic [1:0]  size_r, size_nxt;
  logic [2:0]  unit_r, unit_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic wr_r, wr_nxt, fet_r, fet_nxt, ph_r, ph_nxt, err_r, err_nxt;
  logic w16_r, w16_nxt, sync_r, sync_nxt, rdy_r, rdy_nxt, rspv_r, rspv_nxt;
  logic clk_r, clk_nxt, emp_r, emp_nxt, tgtv_r, tgtv_nxt;
  logic cs_r, cs_nxt, we_r, we_nxt, oe_r, oe_nxt, doe_r, doe_nxt;
  logic [`SD_EXT_ABITS-1:0] ea_r, ea_nxt;
  logic [15:0] eo_r, eo_nxt;

  // SRAM side, external unit and request decode signals.
  logic        mem_we;
  logic [3:0]  mem_be;
  logic [AW-1:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata, bb_word;
  logic [7:0]  lanes;
  logic [63:0] wide_wd, rd_full;
  logic [31:0] word_idx;
  logic [2:0]  nb, units, boff, boff_cur;
  logic        ub2, ub2_cur;
  sysdec_region_t rg;

  // Lanes across two words so an access that crosses a word boundary splits in two phases.
  always_comb begin
    case (size_r)
      2'h0:    lanes = 8'h01 << addr_r[1:0];
      2'h1:    lanes = 8'h03 << addr_r[1:0];
      default: lanes = 8'h0F << addr_r[1:0];
    endcase
    wide_wd  = {32'h00000000, wd_r} << {addr_r[1:0], 3'b000};
    word_idx = (reg_r == RG_ALIAS) ? {14'h0000, addr_r[24:7]}
                                   : {12'h000, addr_r[21:2]};
    mem_addr = AW'(word_idx + {31'h00000000, ph_r});
    bb_word  = (mem_rdata & ~(32'h00000001 << addr_r[6:2]))
             | ({31'h00000000, wd_r[0]} << addr_r[6:2]);
    mem_we    = 1'b0;
    mem_be    = ph_r ? lanes[7:4] : lanes[3:0];
    mem_wdata = ph_r ? wide_wd[63:32] : wide_wd[31:0];
    if (st_r == S_MWR) begin
      mem_we = 1'b1;
    end else if (st_r == S_MCAP && reg_r == RG_ALIAS && wr_r) begin
      mem_we    = 1'b1;
      mem_be    = 4'hF;
      mem_wdata = bb_word;
    end
  end

  sysdec_ram #(.WORDS(SRAM_WORDS), .AW(AW)) u_ram (
    .clk   (ref_clk),
    .we    (mem_we),
    .be    (mem_be),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // Next values of the whole access sequence.
  always_comb begin
    st_nxt = st_r;     reg_nxt = reg_r;   bus_nxt = bus_r;   addr_nxt = addr_r;
    wd_nxt = wd_r;     rd_nxt = rd_r;     buf_nxt = buf_r;   size_nxt = size_r;
    unit_nxt = unit_r; cnt_nxt = cnt_r;   wr_nxt = wr_r;     fet_nxt = fet_r;
    ph_nxt = ph_r;     err_nxt = err_r;   w16_nxt = w16_r;   sync_nxt = sync_r;
    clk_nxt = clk_r;   emp_nxt = emp_r;
    rg = region_of(req_addr);
    rd_full = buf_r;
    // Read data lands at the unit now on the pins, not at the one that follows.
    ub2_cur  = w16_r && !addr_r[0] && size_r != 2'h0;
    boff_cur = ub2_cur ? {unit_r[1:0], 1'b0} : unit_r;
    case (st_r)
      S_IDLE: begin
        if (req_valid && rdy_r) begin
          addr_nxt = req_addr;  wr_nxt = req_write; size_nxt = req_size;
          fet_nxt  = req_fetch; wd_nxt = req_wdata; reg_nxt = rg;
          bus_nxt  = bus_of(req_addr, req_fetch);
          clk_nxt  = req_addr >= `SD_CLK_FIRST && req_addr <= `SD_CLK_LAST;
          emp_nxt  = req_addr >= `SD_EMPC_FIRST && req_addr <= `SD_EMPC_LAST;
          w16_nxt  = cfg_ext_w16;
          sync_nxt = cfg_ext_sync;
          ph_nxt = 1'b0; unit_nxt = 3'h0; cnt_nxt = 8'h00;
          buf_nxt = 64'h0; rd_nxt = 32'h0; err_nxt = 1'b0;
          if (req_fetch && !(rg == RG_CODE || rg == RG_SRAM || rg == RG_ALIAS
                             || (rg == RG_EXTRAM && cfg_ext_w16))) begin
            err_nxt = 1'b1;
            st_nxt  = S_RSP;
          end else if (rg == RG_ALIAS) begin
            st_nxt = S_MRD;
          end else if (rg == RG_SRAM && (req_addr - `SD_SRAM_BASE) < `SD_BB_SIZE) begin
            st_nxt = req_write ? S_MWR : S_MRD;
          end else if (rg == RG_EXTRAM) begin
            // Contents are open to every master; only the span of the external window is checked here.
            if (((req_addr - `SD_EXTRAM_BASE) >> `SD_EXT_ABITS) == 32'h0) begin
              st_nxt = S_EXT;
            end else begin
              err_nxt = 1'b1;
              st_nxt  = S_RSP;
            end
          end else begin
            st_nxt = S_TGT;
          end
        end
      end
      S_MRD: st_nxt = S_MCAP;
      S_MCAP: begin
        if (reg_r == RG_ALIAS) begin
          rd_nxt = wr_r ? 32'h0 : {31'h00000000, mem_rdata[addr_r[6:2]]};
          st_nxt = S_RSP;
        end else begin
          if (ph_r) rd_full[63:32] = mem_rdata;
          else      rd_full[31:0]  = mem_rdata;
          buf_nxt = rd_full;
          if (!ph_r && lanes[7:4] != 4'h0) begin
            ph_nxt = 1'b1;
            st_nxt = S_MRD;
          end else begin
            rd_nxt = 32'(rd_full >> {addr_r[1:0], 3'b000}) & size_mask(size_r);
            st_nxt = S_RSP;
          end
        end
      end
      S_MWR: begin
        if (!ph_r && lanes[7:4] != 4'h0) ph_nxt = 1'b1;
        else st_nxt = S_RSP;
      end
      S_EXT: begin
        if (cnt_r == 8'(EXT_CYC - 1)) begin
          cnt_nxt = 8'h00;
          buf_nxt[{boff_cur, 3'b000} +: 16] = ext_din;
          unit_nxt = unit_r + 3'h1;
          if (unit_r + 3'h1 == units) begin
            rd_nxt = wr_r ? 32'h0 : buf_nxt[31:0] & size_mask(size_r);
            st_nxt = S_RSP;
          end
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      S_TGT: begin
        if (tgt_ready) begin
          rd_nxt = wr_r ? 32'h0 : tgt_rdata;
          st_nxt = S_RSP;
        end
      end
      S_RSP:   st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
    rdy_nxt  = st_nxt == S_IDLE;
    rspv_nxt = st_nxt == S_RSP;
    tgtv_nxt = st_nxt == S_TGT;
  end

  // External unit size: 16-bit units only on an even address of a wide port.
  always_comb begin
    nb    = (size_nxt == 2'h0) ? 3'h1 : (size_nxt == 2'h1) ? 3'h2 : 3'h4; // Size 3 is a word.
    ub2   = w16_nxt && !addr_nxt[0] && size_nxt != 2'h0;
    units = ub2 ? (nb >> 1) : nb;
    boff  = ub2 ? {unit_nxt[1:0], 1'b0} : unit_nxt;
    cs_nxt  = st_nxt == S_EXT;
    we_nxt  = cs_nxt && wr_nxt;
    oe_nxt  = cs_nxt && !wr_nxt;
    doe_nxt = cs_nxt && wr_nxt;
    ea_nxt  = addr_nxt[`SD_EXT_ABITS-1:0] + `SD_EXT_ABITS'(boff);
    eo_nxt  = 16'(wd_nxt >> {boff, 3'b000});
  end

  // Register every state bit and every output.
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      st_r <= S_IDLE;   reg_r <= RG_CODE;  bus_r <= BUS_INSTRUCTION_CODE_BUS; addr_r <= 32'h0;
      wd_r <= 32'h0;    rd_r <= 32'h0;     buf_r <= 64'h0;     size_r <= 2'h0;
      unit_r <= 3'h0;   cnt_r <= 8'h00;    wr_r <= 1'b0;       fet_r <= 1'b0;
      ph_r <= 1'b0;     err_r <= 1'b0;     w16_r <= 1'b0;      sync_r <= 1'b0;
      rdy_r <= 1'b0;    rspv_r <= 1'b0;    clk_r <= 1'b0;      emp_r <= 1'b0;
      tgtv_r <= 1'b0;   cs_r <= 1'b0;      we_r <= 1'b0;       oe_r <= 1'b0;
      doe_r <= 1'b0;    ea_r <= '0;        eo_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;     reg_r <= reg_nxt;   bus_r <= bus_nxt;   addr_r <= addr_nxt;
      wd_r <= wd_nxt;     rd_r <= rd_nxt;     buf_r <= buf_nxt;   size_r <= size_nxt;
      unit_r <= unit_nxt; cnt_r <= cnt_nxt;   wr_r <= wr_nxt;     fet_r <= fet_nxt;
      ph_r <= ph_nxt;     err_r <= err_nxt;   w16_r <= w16_nxt;   sync_r <= sync_nxt;
      rdy_r <= rdy_nxt;   rspv_r <= rspv_nxt; clk_r <= clk_nxt;   emp_r <= emp_nxt;
      tgtv_r <= tgtv_nxt; cs_r <= cs_nxt;     we_r <= we_nxt;     oe_r <= oe_nxt;
      doe_r <= doe_nxt;   ea_r <= ea_nxt;     eo_r <= eo_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign req_ready    = rdy_r;
  assign rsp_valid    = rspv_r;
  assign rsp_rdata    = rd_r;
  assign rsp_err      = err_r;
  assign bus_sel      = bus_r;
  assign region       = reg_r;
  assign clk_blk_sel  = clk_r;
  assign emp_ctrl_sel = emp_r;
  assign tgt_valid    = tgtv_r;
  assign tgt_addr     = addr_r;
  assign tgt_write    = wr_r;
  assign tgt_size     = size_r;
  assign tgt_wdata    = wd_r;
  assign ext_cs       = cs_r;
  assign ext_we       = we_r;
  assign ext_oe       = oe_r;
  assign ext_sync     = sync_r;
  assign ext_addr     = ea_r;
  assign ext_dout     = eo_r;
  assign ext_doe      = doe_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!srst_n);

  sequence s_unit_start;
    st_r == S_EXT && cnt_r == 8'h00;
  endsequence

  property p_code_bus;
    rspv_r && (bus_r == BUS_INSTRUCTION_CODE_BUS || bus_r == BUS_DATA_CODE_BUS) |-> addr_r <= `SD_CODE_LAST;
  endproperty
  a_code_bus: assert property (p_code_bus) else $error("code bus outside code region");

  property p_ppb;
    rspv_r && addr_r >= `SD_INTPER_BASE && addr_r <= `SD_PPB_LAST |-> bus_r == BUS_PPB;
  endproperty
  a_ppb: assert property (p_ppb) else $error("private region not on private bus");

  property p_sys;
    rspv_r && bus_r == BUS_SYSTEM |-> addr_r > `SD_PPB_LAST
      || (addr_r >= `SD_SRAM_BASE && addr_r <= `SD_EXTPER_LAST);
  endproperty
  a_sys: assert property (p_sys) else $error("system bus used out of range");

  property p_alias_rd;
    rspv_r && reg_r == RG_ALIAS && !wr_r && !err_r |-> rd_r[31:1] == 31'h0;
  endproperty
  a_alias_rd: assert property (p_alias_rd) else $error("alias read not 0 or 1");

  property p_ext_len;
    s_unit_start |-> ##1 (cnt_r == 8'h01 || EXT_CYC == 1) ##[EXT_LAST:EXT_LAST]
      (st_r != S_EXT || cnt_r == 8'h00);
  endproperty
  a_ext_len: assert property (p_ext_len) else $error("external unit length wrong");

  property p_fetch_w8;
    rspv_r && fet_r && reg_r == RG_EXTRAM && !w16_r |-> err_r;
  endproperty
  a_fetch_w8: assert property (p_fetch_w8) else $error("fetch from narrow memory");

  property p_span;
    cs_r |-> reg_r == RG_EXTRAM && addr_r[31:24] == 8'h60
      && (!$past(cs_r) || $stable(sync_r));
  endproperty
  a_span: assert property (p_span) else $error("external cycle outside window");

  property p_clk_sel;
    tgtv_r && clk_r |-> addr_r >= `SD_CLK_FIRST && addr_r <= `SD_CLK_LAST;
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock block select wrong");

  property p_emp_sel;
    tgtv_r && addr_r >= `SD_EMPC_FIRST && addr_r <= `SD_EMPC_LAST |-> emp_r;
  endproperty
  a_emp_sel: assert property (p_emp_sel) else $error("port control select missing");

endmodule : sysdec_top

`default_nettype wire
